// file: include/afpm_pkg.sv
package afpm_pkg;
    localparam int unsigned CNT_W = 5;
    localparam logic [4:0] PD_LO_EDGE = 5'h02;
    localparam logic [4:0] PD_HI_EDGE = 5'h0a;
    localparam logic [4:0] FRAME_EDGES = 5'h10;
    localparam logic [4:0] LEAD_ZEROS = 5'h04;
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;
    localparam logic [11:0] RESULT_RST = 12'h000;
    typedef enum logic [1:0] {
        AFPM_NORMAL,
        AFPM_DOWN,
        AFPM_WAKING
    } afpm_pwr_t;
endpackage

// file: rtl/afpm_ctrl.sv
// Summary of operation
// - Chip-select rise point picks normal or power-down
// - Chip-select fall samples input, starts conversion
// - Rise after tenth edge aborts, stays powered
// - Twelve-bit frame takes sixteen serial clocks
// - Ten-bit and eight-bit frames also take sixteen clocks
// - Power-down window between second and tenth edges
// - Rise in window powers down, aborts, tristates
// - Rise before second edge keeps normal mode
// - Analog circuitry off while powered down
// - Fall in power-down starts wake-up
// - Fully powered after sixteen dummy clocks
// - Early rise in wake frame returns power-down
// - Sixteen-bit word, four zeros, MSB first
// - Serial clock shifts data and drives conversion
// - Select fall holds sample, drives output
// - Output released on sixteenth falling edge
module afpm_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [1:0] res_sel,
    input wire logic [11:0] conv_result,
    output logic serial_result_out,
    output logic serial_result_oe,
    output logic sample_hold,
    output logic conv_start,
    output logic conv_step,
    output logic analog_on,
    output logic pwr_not_ready
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic ck_s1_q, ck_s2_q, ck_s3_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            ck_s1_q <= 1'b1;
            ck_s2_q <= 1'b1;
            ck_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            ck_s1_q <= sclk;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
        end
    end

    wire cs_fall = cs_s3_q && !cs_s2_q;
    wire cs_rise = !cs_s3_q && cs_s2_q;
    wire ck_fall = ck_s3_q && !ck_s2_q && !cs_s2_q;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    afpm_pkg::afpm_pwr_t pwr_q, pwr_d;
    logic [4:0] edges_q, edges_d;
    logic active_q, active_d;
    logic [15:0] word_q, word_d;
    logic oe_q, oe_d;
    logic sdo_q, sdo_d;

    function automatic logic [15:0] afpm_pack(input logic [1:0] res,
                                               input logic [11:0] r);
        logic [15:0] w;
        w = 16'h0000;
        case (res)
            afpm_pkg::RES_10: w = {4'h0, r[9:0], 2'h0};
            afpm_pkg::RES_8:  w = {4'h0, r[7:0], 4'h0};
            default:          w = {4'h0, r};
        endcase
        return w;
    endfunction

    // Bit 15 leaves at the select fall, so all sixteen fit in one frame
    wire [15:0] packed_w = afpm_pack(res_sel, conv_result);

    wire last_edge = ck_fall && (edges_q == afpm_pkg::FRAME_EDGES - 5'h01);
    // Count reached before the rise; edges_q holds falling edges so far
    wire in_pd_win = (edges_q >= afpm_pkg::PD_LO_EDGE) &&
                     (edges_q < afpm_pkg::PD_HI_EDGE);
    wire below_ten = edges_q < afpm_pkg::PD_HI_EDGE;

    always_comb begin
        pwr_d = pwr_q;
        edges_d = edges_q;
        active_d = active_q;
        word_d = word_q;
        oe_d = oe_q;
        sdo_d = sdo_q;
        if (cs_fall) begin
            active_d = 1'b1;
            edges_d = '0;
            oe_d = 1'b1;
            sdo_d = packed_w[15];
            word_d = {packed_w[14:0], 1'b0};
            if (pwr_q == afpm_pkg::AFPM_DOWN) begin
                pwr_d = afpm_pkg::AFPM_WAKING;
            end
        end else if (cs_rise && active_q) begin
            active_d = 1'b0;
            oe_d = 1'b0;
            if (pwr_q == afpm_pkg::AFPM_WAKING) begin
                if (below_ten) begin
                    pwr_d = afpm_pkg::AFPM_DOWN;
                end
            end else if (in_pd_win) begin
                pwr_d = afpm_pkg::AFPM_DOWN;
            end
            // Normal-mode rise before second edge leaves mode alone
        end else if (ck_fall && active_q) begin
            edges_d = edges_q + 5'h01;
            sdo_d = word_q[15];
            word_d = {word_q[14:0], 1'b0};
            if (last_edge) begin
                active_d = 1'b0;
                oe_d = 1'b0;
                if (pwr_q == afpm_pkg::AFPM_WAKING) begin
                    pwr_d = afpm_pkg::AFPM_NORMAL;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pwr_q <= afpm_pkg::AFPM_NORMAL;
            edges_q <= '0;
            active_q <= 1'b0;
            word_q <= '0;
            oe_q <= 1'b0;
            sdo_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            edges_q <= edges_d;
            active_q <= active_d;
            word_q <= word_d;
            oe_q <= oe_d;
            sdo_q <= sdo_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign serial_result_out = sdo_q;
    assign serial_result_oe = oe_q;
    assign sample_hold = active_q;
    assign conv_start = cs_fall;
    assign conv_step = ck_fall && active_q;
    assign analog_on = (pwr_q != afpm_pkg::AFPM_DOWN);
    assign pwr_not_ready = (pwr_q != afpm_pkg::AFPM_NORMAL);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    pd_window_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && active_q && pwr_q == afpm_pkg::AFPM_NORMAL && in_pd_win)
        |=> pwr_q == afpm_pkg::AFPM_DOWN)
        else $error("no power-down in window");
    pd_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && active_q && pwr_q == afpm_pkg::AFPM_NORMAL && in_pd_win)
        |=> !analog_on && !oe_q && !sample_hold)
        else $error("still powered after window rise");
    early_rise_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && active_q && pwr_q == afpm_pkg::AFPM_NORMAL &&
         edges_q < afpm_pkg::PD_LO_EDGE) |=> pwr_q == afpm_pkg::AFPM_NORMAL)
        else $error("glitch powered down");
    late_rise_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && active_q && !below_ten &&
         pwr_q == afpm_pkg::AFPM_NORMAL)
        |=> pwr_q == afpm_pkg::AFPM_NORMAL && !oe_q)
        else $error("late rise wrong");
    wake_start_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_fall && pwr_q == afpm_pkg::AFPM_DOWN)
        |=> pwr_q == afpm_pkg::AFPM_WAKING && analog_on)
        else $error("wake not started");
    wake_abort_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && active_q && pwr_q == afpm_pkg::AFPM_WAKING && below_ten)
        |=> pwr_q == afpm_pkg::AFPM_DOWN)
        else $error("wake not aborted");
    wake_done_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (last_edge && active_q && !cs_fall && !cs_rise &&
         pwr_q == afpm_pkg::AFPM_WAKING)
        |=> pwr_q == afpm_pkg::AFPM_NORMAL)
        else $error("wake not done");
    release_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (last_edge && active_q && !cs_fall && !cs_rise)
        |=> !oe_q && !active_q)
        else $error("output not released");
    drive_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        cs_fall |=> oe_q && sample_hold && edges_q == 5'h00)
        else $error("frame not opened");
    first_bit_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        cs_fall |=> serial_result_out == $past(packed_w[15]))
        else $error("first bit wrong");
    shift_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (conv_step && !cs_fall && !last_edge)
        |=> serial_result_out == $past(word_q[15]))
        else $error("bit not shifted");
    flag_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        pwr_not_ready == (pwr_q != afpm_pkg::AFPM_NORMAL) &&
        (analog_on || pwr_not_ready))
        else $error("power flag wrong");
endmodule

// file: tb/adc_frame_power_mode_control_tb_top.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module adc_frame_power_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, cs_n, sclk, out, oe, hold, start, step, aon, pnr;
    logic [1:0] res_sel;
    logic [11:0] conv_result;
    int fails = 0, comparisons = 0, n_start = 0, n_step = 0;

    afpm_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n),
        .sclk(sclk), .res_sel(res_sel), .conv_result(conv_result),
        .serial_result_out(out), .serial_result_oe(oe),
        .sample_hold(hold), .conv_start(start), .conv_step(step),
        .analog_on(aon), .pwr_not_ready(pnr));
    afpm_host u_host (.clk_sys(clk_sys), .serial_result_out(out),
        .cs_n(cs_n), .sclk(sclk));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (start === 1'b1) n_start++;
        if (step === 1'b1) n_step++;
    end

    task automatic stop_test();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_full(input logic [1:0] rs, input logic [15:0] mask,
                          input logic [15:0] exp);
        res_sel <= rs;
        n_start = 0;
        n_step = 0;
        u_host.frame(16);
        `CHK(u_host.word & mask, exp)
        `CHK(oe, 1'b0)
        `CHK(hold, 1'b0)
        `CHK(n_step, 16)
        `CHK(n_start, 1)
    endtask

    task automatic t_cut(input int n, input logic aon_e, input logic pnr_e);
        u_host.frame(n);
        `CHK(oe, 1'b0)
        `CHK(aon, aon_e)
        `CHK(pnr, pnr_e)
    endtask

    initial begin
        rst_n = 1'b0;
        res_sel = afpm_pkg::RES_12;
        conv_result = 12'ha5d;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_full(afpm_pkg::RES_12, 16'hffff, 16'h0a5d);
        t_full(afpm_pkg::RES_10, 16'hffff, 16'h0974);
        t_full(afpm_pkg::RES_8, 16'hffff, 16'h05d0);
        res_sel <= afpm_pkg::RES_12;
        t_cut(1, 1'b1, 1'b0);
        t_cut(10, 1'b1, 1'b0);
        t_cut(9, 1'b0, 1'b1);
        t_cut(4, 1'b0, 1'b1);
        t_cut(12, 1'b1, 1'b1);
        t_cut(16, 1'b1, 1'b0);
        t_cut(2, 1'b0, 1'b1);
        t_cut(16, 1'b1, 1'b0);
        t_full(afpm_pkg::RES_12, 16'hffff, 16'h0a5d);
        stop_test();
    end

    // Whole run needs about 25 us; a hang is cut well beyond that
    initial begin
        #200us;
        fails++;
        stop_test();
    end
endmodule

// file: tb/afpm_host.sv
module afpm_host (
    input wire logic clk_sys,
    input wire logic serial_result_out,
    output logic cs_n,
    output logic sclk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word;

    // Select and serial clock idle high and stand still between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        word = 16'h0000;
    end

    // Half period of 80 ns is eight system cycles
    task automatic half_wait();
        repeat (8) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // One frame of n serial clock falls; data taken at each of the first sixteen falls
    // ------------------------------------------------------------
    task automatic frame(input int n);
        word = 16'h0000;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        half_wait();
        for (int k = 1; k <= n; k++) begin
            // Bit is settled here; the part moves it only after this fall
            if (k <= 16) word = {word[14:0], serial_result_out};
            sclk <= 1'b0;
            half_wait();
            sclk <= 1'b1;
            half_wait();
        end
        // Caller picks n to keep power, power down or wake up
        cs_n <= 1'b1;
        repeat (16) @(posedge clk_sys);
    endtask
endmodule
